// ===== hw/panel_ctrl.v
// front-panel, online/alarm state and start-up mode controller
//
// Design decisions made here: the placing of the registers and the strobed register port.
`include "panel_defs.vh"

module panel_ctrl #(
    parameter [`CNT_W-1:0] DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
    parameter [`CNT_W-1:0] BUZZ_CYCLES = `BUZZ_CYCLES
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_ce,
    input wire i_line_key,
    input wire i_paper_advance_key,
    input wire i_head_fault,
    input wire i_paper_near_end,
    input wire i_paper_out,
    input wire i_self_print_done,
    input wire i_buf_clear_done,
    input wire [`ADDR_W-1:0] i_addr,
    input wire [`DATA_W-1:0] i_wdata,
    input wire i_we,
    input wire i_re,
    output reg [`DATA_W-1:0] o_rdata,
    output wire o_online_lamp,
    output wire o_alarm_lamp,
    output wire o_print_enable,
    output wire o_feed,
    output wire o_paper_near_end_output,
    output wire o_buzzer,
    output wire o_self_print,
    output wire o_buf_clear,
    output wire o_irq
);
    localparam [1:0] PH_WAIT = 2'b00;
    localparam [1:0] PH_CLEAR = 2'b01;
    localparam [1:0] PH_SELF = 2'b10;
    localparam [1:0] PH_RUN = 2'b11;

    wire line_lvl, line_press, adv_lvl, adv_press;
    reg [`PIN_N-1:0] p1_r, p2_r, p3_r, pin_r;
    wire [`PIN_N-1:0] pins_in;
    wire fault, near, paper_out;
    reg [1:0] phase_r;
    reg [3:0] wait_r;
    reg online_r, alarm_r, fault_d_r, near_d_r;
    reg pe_mode_r;
    reg print_en_r, feed_r, near_out_r;
    reg [`CNT_W-1:0] buzz_r;
    reg [`IRQ_W-1:0] irq_en_r;
    reg [`IRQ_W-1:0] ev_set;
    wire [`IRQ_W-1:0] irq_stat;
    wire clr_we;
    wire buzz_start;
    reg line_arm_r, adv_arm_r;
    wire line_hit, adv_hit;

    function sel;
        input [`ADDR_W-1:0] a;
        input [`ADDR_W-1:0] target;
        begin
            sel = (a == target);
        end
    endfunction

    key_debounce #(
        .CNT(DEBOUNCE_CYCLES)
    ) line_deb (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_pin(i_line_key),
        .o_level(line_lvl),
        .o_press(line_press)
    );

    key_debounce #(
        .CNT(DEBOUNCE_CYCLES)
    ) adv_deb (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_pin(i_paper_advance_key),
        .o_level(adv_lvl),
        .o_press(adv_press)
    );

    // mechanism status pins: three stages, change taken once 2nd and 3rd agree
    assign pins_in = {i_paper_out, i_paper_near_end, i_head_fault};
    genvar g;
    generate
        for (g = 0; g < `PIN_N; g = g + 1) begin : pin_g
            always @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    p1_r[g] <= 1'b0;
                    p2_r[g] <= 1'b0;
                    p3_r[g] <= 1'b0;
                    pin_r[g] <= 1'b0;
                end else if (i_ce) begin
                    p1_r[g] <= pins_in[g];
                    p2_r[g] <= p1_r[g];
                    p3_r[g] <= p2_r[g];
                    if (p2_r[g] == p3_r[g])
                        pin_r[g] <= p3_r[g];
                end
            end
        end
    endgenerate

    assign fault = pin_r[`PIN_FAULT];
    assign near = pin_r[`PIN_NEAR];
    assign paper_out = pin_r[`PIN_OUT];

    // start-up sequencing
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            phase_r <= PH_WAIT;
            wait_r <= 4'h0;
        end else if (i_ce) begin
            case (phase_r)
                PH_WAIT: begin
                    // give the synchronisers time to fill before sampling
                    if (wait_r != `START_WAIT) begin
                        wait_r <= wait_r + 4'h1;
                    end else if (adv_lvl) begin
                        if (pe_mode_r && paper_out)
                            phase_r <= PH_RUN;
                        else
                            phase_r <= PH_SELF;
                    end else if (line_lvl) begin
                        phase_r <= PH_CLEAR;
                    end else begin
                        phase_r <= PH_RUN;
                    end
                end
                PH_SELF: begin
                    // internal mode may be chosen after start-up, so keep checking
                    if (pe_mode_r && paper_out)
                        phase_r <= PH_RUN;
                    else if (i_self_print_done)
                        phase_r <= PH_RUN;
                end
                PH_CLEAR: begin
                    if (i_buf_clear_done)
                        phase_r <= PH_RUN;
                end
                PH_RUN: begin
                    phase_r <= PH_RUN;
                end
                default: begin
                    phase_r <= PH_WAIT;
                end
            endcase
        end
    end

    assign o_self_print = (phase_r == PH_SELF);
    assign o_buf_clear = (phase_r == PH_CLEAR);

    // a key still held from power-on was spent on the start-up choice,
    // so its late debounced edge must not also toggle or feed
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            line_arm_r <= 1'b0;
            adv_arm_r <= 1'b0;
        end else if (i_ce && phase_r == PH_RUN) begin
            if (!line_lvl)
                line_arm_r <= 1'b1;
            if (!adv_lvl)
                adv_arm_r <= 1'b1;
        end
    end

    assign line_hit = line_press && line_arm_r;
    assign adv_hit = adv_press && adv_arm_r;

    // online and alarm state
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            online_r <= 1'b0;
            alarm_r <= 1'b0;
            fault_d_r <= 1'b0;
            near_d_r <= 1'b0;
        end else if (i_ce) begin
            fault_d_r <= fault;
            near_d_r <= near;
            if (phase_r != PH_RUN) begin
                online_r <= 1'b0;
            end else if (line_hit && !alarm_r) begin
                online_r <= ~online_r;
            end
            // a new fault edge wins over a clearing press
            if (fault && !fault_d_r)
                alarm_r <= 1'b1;
            else if (line_hit && alarm_r && phase_r == PH_RUN)
                alarm_r <= 1'b0;
        end
    end

    assign o_online_lamp = online_r;
    assign o_alarm_lamp = alarm_r;

    // print gate, feed pulse, near-end handling
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            print_en_r <= 1'b0;
            feed_r <= 1'b0;
            near_out_r <= 1'b0;
        end else if (i_ce) begin
            // internal mode halts printing until the paper is replaced
            print_en_r <= (phase_r == PH_RUN) && online_r
                && !alarm_r
                && !(pe_mode_r && near);
            feed_r <= adv_hit && !online_r && !alarm_r
                && (phase_r == PH_RUN);
            near_out_r <= near && !pe_mode_r;
        end
    end

    assign o_print_enable = print_en_r;
    assign o_feed = feed_r;
    assign o_paper_near_end_output = near_out_r;

    // buzzer timer
    assign buzz_start = (phase_r == PH_CLEAR && i_buf_clear_done)
        || (pe_mode_r && near && !near_d_r && phase_r == PH_RUN);

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            buzz_r <= {`CNT_W{1'b0}};
        end else if (i_ce) begin
            if (buzz_start)
                buzz_r <= BUZZ_CYCLES;
            else if (buzz_r != {`CNT_W{1'b0}})
                buzz_r <= buzz_r - 1'b1;
        end
    end

    assign o_buzzer = (buzz_r != {`CNT_W{1'b0}});

    // events
    always @* begin
        ev_set = {`IRQ_W{1'b0}};
        ev_set[`EV_ALARM] = fault && !fault_d_r;
        ev_set[`EV_NEAR_END] = near && !near_d_r;
        ev_set[`EV_SELF_DONE] = (phase_r == PH_SELF) && i_self_print_done;
        ev_set[`EV_CLEAR_DONE] = (phase_r == PH_CLEAR) && i_buf_clear_done;
        ev_set[`EV_ONLINE] = line_hit && !alarm_r && (phase_r == PH_RUN);
    end

    assign clr_we = i_we && sel(i_addr, `ADDR_IRQ_CLR);

    event_irq irq_u (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_set(ev_set),
        .i_clr_we(clr_we),
        .i_clr(i_wdata[`IRQ_W-1:0]),
        .i_en(irq_en_r),
        .o_stat(irq_stat),
        .o_irq(o_irq)
    );

    // register writes
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pe_mode_r <= `CTRL_RESET;
            irq_en_r <= `IRQ_EN_RESET;
        end else if (i_ce && i_we) begin
            if (sel(i_addr, `ADDR_CTRL))
                pe_mode_r <= i_wdata[`CTRL_PE_MODE];
            if (sel(i_addr, `ADDR_IRQ_EN))
                irq_en_r <= i_wdata[`IRQ_W-1:0];
        end
    end

    // register reads, data valid the cycle after the strobe only
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= {`DATA_W{1'b0}};
        end else if (i_ce) begin
            o_rdata <= {`DATA_W{1'b0}};
            if (i_re) begin
                if (sel(i_addr, `ADDR_CTRL))
                    o_rdata[`CTRL_PE_MODE] <= pe_mode_r;
                else if (sel(i_addr, `ADDR_STATUS)) begin
                    o_rdata[`ST_ONLINE] <= online_r;
                    o_rdata[`ST_ALARM] <= alarm_r;
                    o_rdata[`ST_SELF] <= (phase_r == PH_SELF);
                    o_rdata[`ST_CLEAR] <= (phase_r == PH_CLEAR);
                    o_rdata[`ST_NEAR_END] <= near;
                    o_rdata[`ST_PAPER_OUT] <= paper_out;
                    o_rdata[`ST_PHASE_HI-1:`ST_PHASE_LO] <= phase_r;
                end else if (sel(i_addr, `ADDR_IRQ_STAT))
                    o_rdata[`IRQ_W-1:0] <= irq_stat;
                else if (sel(i_addr, `ADDR_IRQ_EN))
                    o_rdata[`IRQ_W-1:0] <= irq_en_r;
            end
        end
    end
endmodule // panel_ctrl

// ===== hw/panel_defs.vh
// constants for the printer front-panel state controller
`ifndef PANEL_DEFS_VH
`define PANEL_DEFS_VH

// sized to the counter width so the products fit the count registers
`define CLK_MHZ 26'hc8
`define DEBOUNCE_TIME_US 26'h2710
`define BUZZ_TIME_US 26'h30d40
`define DEBOUNCE_CYCLES (`DEBOUNCE_TIME_US * `CLK_MHZ)
`define BUZZ_CYCLES (`BUZZ_TIME_US * `CLK_MHZ)
`define CNT_W 26
`define START_WAIT 4'h8

`define ADDR_W 8
`define DATA_W 32
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_IRQ_STAT 8'h08
`define ADDR_IRQ_CLR 8'h0c
`define ADDR_IRQ_EN 8'h10

`define CTRL_PE_MODE 0
`define CTRL_RESET 1'b0

`define ST_ONLINE 0
`define ST_ALARM 1
`define ST_SELF 2
`define ST_CLEAR 3
`define ST_NEAR_END 4
`define ST_PAPER_OUT 5
`define ST_PHASE_LO 6
`define ST_PHASE_HI 8

`define IRQ_W 5
`define EV_ALARM 0
`define EV_NEAR_END 1
`define EV_SELF_DONE 2
`define EV_CLEAR_DONE 3
`define EV_ONLINE 4
`define IRQ_EN_RESET 5'h00

`define PIN_N 3
`define PIN_FAULT 0
`define PIN_NEAR 1
`define PIN_OUT 2

`endif

// ===== hw/key_debounce.v
// key synchroniser and debouncer producing one press pulse per actuation
`include "panel_defs.vh"

module key_debounce #(
    parameter [`CNT_W-1:0] CNT = `DEBOUNCE_CYCLES
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_ce,
    input wire i_pin,
    output wire o_level,
    output wire o_press
);
    reg s1_r, s2_r, s3_r;
    reg lvl_r, deb_r, press_r;
    reg [`CNT_W-1:0] cnt_r;

    assign o_level = lvl_r;
    assign o_press = press_r;

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            lvl_r <= 1'b0;
            deb_r <= 1'b0;
            press_r <= 1'b0;
            cnt_r <= {`CNT_W{1'b0}};
        end else if (i_ce) begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            press_r <= 1'b0;
            if (s2_r == s3_r)
                lvl_r <= s3_r;
            // bounce restarts the count, so one actuation gives one edge
            if (lvl_r == deb_r) begin
                cnt_r <= {`CNT_W{1'b0}};
            end else if (cnt_r >= CNT) begin
                cnt_r <= {`CNT_W{1'b0}};
                deb_r <= lvl_r;
                press_r <= lvl_r;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule // key_debounce

// ===== hw/event_irq.v
// sticky event status with enable mask and write-one-to-clear
`include "panel_defs.vh"

module event_irq (
    input wire i_clk,
    input wire i_rst,
    input wire i_ce,
    input wire [`IRQ_W-1:0] i_set,
    input wire i_clr_we,
    input wire [`IRQ_W-1:0] i_clr,
    input wire [`IRQ_W-1:0] i_en,
    output wire [`IRQ_W-1:0] o_stat,
    output wire o_irq
);
    reg [`IRQ_W-1:0] stat_r;
    genvar g;

    generate
        for (g = 0; g < `IRQ_W; g = g + 1) begin : bit_g
            always @(posedge i_clk or posedge i_rst) begin
                if (i_rst)
                    stat_r[g] <= 1'b0;
                else if (i_ce) begin
                    // set beats a clear in the same cycle
                    if (i_set[g])
                        stat_r[g] <= 1'b1;
                    else if (i_clr_we && i_clr[g])
                        stat_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign o_stat = stat_r;
    assign o_irq = |(stat_r & i_en);
endmodule // event_irq

// ===== testbench/panel_ctrl_assertions.sv
// concurrent checks on the front-panel controller ports
`include "panel_defs.vh"
module panel_ctrl_checker #(
    parameter [`CNT_W-1:0] DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
    parameter [`CNT_W-1:0] BUZZ_CYCLES = `BUZZ_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_head_fault,
    input wire logic i_paper_near_end,
    input wire logic i_self_print_done,
    input wire logic i_buf_clear_done,
    input wire logic i_re,
    input wire logic [`DATA_W-1:0] o_rdata,
    input wire logic o_online_lamp,
    input wire logic o_alarm_lamp,
    input wire logic o_print_enable,
    input wire logic o_feed,
    input wire logic o_paper_near_end_output,
    input wire logic o_buzzer,
    input wire logic o_self_print,
    input wire logic o_buf_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence near_low;
        !i_paper_near_end [*8];
    endsequence
    sequence self_gone;
        ##[1:3] !o_self_print;
    endsequence
    // buzzer may load with the phase change or just after it
    sequence clear_gone;
        ##[1:3] !o_buf_clear ##[0:2] o_buzzer;
    endsequence
    print_online_a: assert property (o_print_enable |-> $past(o_online_lamp))
        else $error("print enabled while offline");
    print_alarm_a: assert property (o_print_enable |-> !$past(o_alarm_lamp))
        else $error("print enabled during alarm");
    feed_offline_a: assert property (o_feed |-> !$past(o_online_lamp) && !$past(o_alarm_lamp))
        else $error("feed while online or in alarm");
    feed_pulse_a: assert property (o_feed |=> !o_feed)
        else $error("feed longer than one cycle");
    online_noalarm_a: assert property ($changed(o_online_lamp) |-> !$past(o_alarm_lamp))
        else $error("online toggled by alarm clearing press");
    online_run_a: assert property (o_online_lamp |-> !o_self_print && !o_buf_clear)
        else $error("online lamp outside normal run");
    fault_alarm_a: assert property ($rose(i_head_fault) |-> ##[1:8] o_alarm_lamp)
        else $error("head fault did not raise alarm");
    near_gone_a: assert property (near_low |=> !o_paper_near_end_output)
        else $error("near-end output without sensor");
    self_end_a: assert property (o_self_print && i_self_print_done |-> self_gone)
        else $error("self print did not end");
    clear_end_a: assert property (o_buf_clear && i_buf_clear_done |-> clear_gone)
        else $error("buffer clear end without buzzer");
    buzz_len_a: assert property ($rose(o_buzzer) |-> o_buzzer [*8])
        else $error("buzzer too short");
    rdata_idle_a: assert property (!$past(i_re) |-> o_rdata == '0)
        else $error("read data outside read slot");
endmodule // panel_ctrl_checker

bind panel_ctrl panel_ctrl_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
    .BUZZ_CYCLES(BUZZ_CYCLES)) panel_ctrl_checker_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_head_fault(i_head_fault), .i_paper_near_end(i_paper_near_end),
    .i_self_print_done(i_self_print_done), .i_buf_clear_done(i_buf_clear_done),
    .i_re(i_re), .o_rdata(o_rdata), .o_online_lamp(o_online_lamp),
    .o_alarm_lamp(o_alarm_lamp), .o_print_enable(o_print_enable), .o_feed(o_feed),
    .o_paper_near_end_output(o_paper_near_end_output), .o_buzzer(o_buzzer),
    .o_self_print(o_self_print), .o_buf_clear(o_buf_clear));

// ===== testbench/mech_model.sv
// behavioural print mechanism answering self print and buffer clear
module mech_model (
    input wire logic i_clk,
    input wire logic [7:0] i_delay,
    input wire logic i_self_print,
    input wire logic i_buf_clear,
    output logic o_self_print_done,
    output logic o_buf_clear_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_r = 0;
    initial begin
        o_self_print_done = 1'b0;
        o_buf_clear_done = 1'b0;
    end
    // delay set by the bench, so both prompt and slow answers are seen
    always @(posedge i_clk) begin
        cnt_r <= (i_self_print || i_buf_clear) ? cnt_r + 1 : 0;
        o_self_print_done <= i_self_print && cnt_r == i_delay;
        o_buf_clear_done <= i_buf_clear && cnt_r == i_delay;
    end
endmodule // mech_model

// ===== testbench/tb.sv
// self-checking bench for the front-panel state controller
`include "panel_defs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0, i_rst = 1'b1, i_line_key = 1'b0, i_paper_advance_key = 1'b0;
    logic i_head_fault = 1'b0, i_paper_near_end = 1'b0, i_paper_out = 1'b0;
    logic i_we = 1'b0, i_re = 1'b0, ce = 1'b1;
    logic [7:0] i_addr = 8'h00, delay = 8'h04;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic o_online_lamp, o_alarm_lamp, o_print_enable, o_feed, o_near, o_buzzer;
    logic o_self_print, o_buf_clear, o_irq, self_done, clr_done;
    int miscompares = 0, checked = 0, feeds = 0, cycles = 0;
    always #2.5 i_clk = ~i_clk;
    panel_ctrl #(.DEBOUNCE_CYCLES(26'h4), .BUZZ_CYCLES(26'ha)) panel_ctrl_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_line_key(i_line_key),
        .i_paper_advance_key(i_paper_advance_key), .i_head_fault(i_head_fault),
        .i_paper_near_end(i_paper_near_end), .i_paper_out(i_paper_out),
        .i_self_print_done(self_done), .i_buf_clear_done(clr_done), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
        .o_online_lamp(o_online_lamp), .o_alarm_lamp(o_alarm_lamp),
        .o_print_enable(o_print_enable), .o_feed(o_feed), .o_paper_near_end_output(o_near),
        .o_buzzer(o_buzzer), .o_self_print(o_self_print), .o_buf_clear(o_buf_clear),
        .o_irq(o_irq));
    mech_model mech_model_inst (.i_clk(i_clk), .i_delay(delay), .i_self_print(o_self_print),
        .i_buf_clear(o_buf_clear), .o_self_print_done(self_done), .o_buf_clear_done(clr_done));
    task automatic final_report;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_we <= 1'b1;
        @(posedge i_clk);
        i_we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge i_clk);
        i_addr <= a;
        i_re <= 1'b1;
        @(posedge i_clk);
        i_re <= 1'b0;
        // look mid-cycle, then return on an edge so later drives stay aligned
        @(negedge i_clk);
        chk(name, o_rdata, exp);
        @(posedge i_clk);
    endtask
    // held well past debounce both ways, so one actuation is one press
    task automatic press(input bit line);
        @(posedge i_clk);
        if (line)
            i_line_key <= 1'b1;
        else
            i_paper_advance_key <= 1'b1;
        tick(20);
        i_line_key <= 1'b0;
        i_paper_advance_key <= 1'b0;
        tick(20);
    endtask
    // keys set with reset so they are settled long before it lifts
    task automatic restart(input bit line, input bit adv, input bit pe);
        i_rst <= 1'b1;
        i_line_key <= line;
        i_paper_advance_key <= adv;
        tick(10);
        i_rst <= 1'b0;
        if (pe)
            wr(`ADDR_CTRL, 32'h1);
        tick(12);
        i_line_key <= 1'b0;
        i_paper_advance_key <= 1'b0;
    endtask
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (o_feed === 1'b1)
            feeds <= feeds + 1;
        if (cycles == 4000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        tick(10);
        i_rst <= 1'b0;
        tick(12);
        rd(`ADDR_STATUS, 32'hc0, "status start");
        rd(`ADDR_IRQ_EN, 32'h0, "irq en reset");
        wr(`ADDR_IRQ_STAT, 32'h1f);
        rd(`ADDR_IRQ_STAT, 32'h0, "irq stat ro");
        rd(8'h20, 32'h0, "unmapped");
        press(1);
        chk("online", o_online_lamp, 1);
        rd(`ADDR_STATUS, 32'hc1, "status online");
        rd(`ADDR_IRQ_STAT, 32'h10, "online event");
        chk("irq masked", o_irq, 0);
        wr(`ADDR_IRQ_EN, 32'h10);
        tick(1);
        chk("irq on", o_irq, 1);
        wr(`ADDR_IRQ_CLR, 32'h10);
        tick(1);
        chk("irq off", o_irq, 0);
        // a frozen block must not see a press
        ce <= 1'b0;
        press(1);
        ce <= 1'b1;
        chk("ce frozen", o_online_lamp, 1);
        press(0);
        chk("feed online", feeds, 0);
        chk("print online", o_print_enable, 1);
        press(1);
        chk("offline", o_online_lamp, 0);
        chk("print offline", o_print_enable, 0);
        press(0);
        chk("feed offline", feeds, 1);
        i_head_fault <= 1'b1;
        tick(10);
        chk("alarm", o_alarm_lamp, 1);
        press(0);
        chk("feed alarm", feeds, 1);
        i_head_fault <= 1'b0;
        press(1);
        chk("alarm clear", o_alarm_lamp, 0);
        chk("no toggle", o_online_lamp, 0);
        press(1);
        i_head_fault <= 1'b1;
        tick(10);
        chk("print alarm", o_print_enable, 0);
        press(1);
        chk("online kept", o_online_lamp, 1);
        chk("print back", o_print_enable, 1);
        i_head_fault <= 1'b0;
        i_paper_near_end <= 1'b1;
        tick(8);
        chk("near pin", o_near, 1);
        chk("buzz pin mode", o_buzzer, 0);
        i_paper_near_end <= 1'b0;
        wr(`ADDR_CTRL, 32'h1);
        rd(`ADDR_CTRL, 32'h1, "ctrl rw");
        i_paper_near_end <= 1'b1;
        tick(8);
        chk("near internal", o_near, 0);
        chk("buzz internal", o_buzzer, 1);
        chk("print halted", o_print_enable, 0);
        i_paper_near_end <= 1'b0;
        tick(20);
        delay <= 8'h28;
        restart(0, 1, 0);
        chk("self on", o_self_print, 1);
        tick(60);
        chk("self off", o_self_print, 0);
        rd(`ADDR_IRQ_STAT, 32'h04, "self done");
        delay <= 8'h04;
        restart(1, 0, 0);
        chk("clear on", o_buf_clear, 1);
        tick(6);
        chk("clear off", o_buf_clear, 0);
        chk("clear buzz", o_buzzer, 1);
        i_paper_out <= 1'b1;
        restart(0, 1, 1);
        chk("no self", o_self_print, 0);
        rd(`ADDR_STATUS, 32'he0, "status paper out");
        chk("no start feed", feeds, 1);
        final_report();
    end
endmodule // tb
